// [rtl/fbjz_core.sv]
// Function
// - jitter turns on with feedback at least 1.0 V and bulk at least 175 V
// - jitter turns off with feedback under 0.9 V or bulk under 150 V
// - jitter sweeps peak limit plus/minus 15.625 mV over a 1 ms period
// - feedback under entry level starts burst mode in a burst-off phase
// - burst-on above wake level, burst-off at pause level
// - first burst gate pulse comes 26.6 us after the wake crossing
// - burst pulse pattern is fixed, independent of feedback
// - burst pulses share one period; peaks ramp then hold the fourth
// - feedback above exit level leaves burst mode at once
// - after exit one pulse uses the exit peak, then the frequency law
// - mode selector picks burst, fixed, frequency-reduction or resonant
// - more than 20 V below the zvs line level the aux pulse is suppressed, valley mode
// - valley mode moves to the next later valley at the frequency limit
// - valley steps up to the sixth, then frequency reduction follows
// - aux gate enabled by line level with 20 V hysteresis
// - zero crossings enable main gate generation in resonant mode
// - aux pulse first, both gates off for dead time, then main gate
// - dead time between aux end and main turn-on is 24 clocks, 236 ns rounded up to 240 ns
// - forced-resonant main period is timed directly, not by valley
// - aux pulse starts a set delay after a zero crossing
// - aux width in 15.8 ns units from bulk and zero-crossing terms
// - bulk voltage derived from line sense current over 102 kOhm
// - negative magnetization set through configurable coefficients
`timescale 1ns/1ps
module fbjz_core import fbjz_pkg::*; #(
    parameter int JIT_PERIOD = JIT_PERIOD_CYC,
    parameter int DCM1_PERIOD = DCM1_PERIOD_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [11:0] feedback_pin_mv,
    input wire logic [11:0] line_sense_ua,
    input wire logic [11:0] zcd_mv,
    input wire logic zcd_pulse,
    input wire logic cs_trip,
    output logic main_gate_output,
    output logic zvs_gate_output,
    output logic [19:0] peak_limit_uv
);
    localparam int JIT_AMP = JIT_AMP_UV * JIT_SUB;
    localparam int JIT_STEP = 4 * JIT_AMP / JIT_PERIOD;

    // the triangle sweep must close exactly on the amplitude
    if (JIT_PERIOD < 4 || JIT_STEP * JIT_PERIOD != 4 * JIT_AMP
        || DCM1_PERIOD < 2 || DCM1_PERIOD > 65535) begin : g_bad
        $error("fbjz_core: unsupported period parameter");
    end

    function automatic logic [31:0] byte_merge(input logic [31:0] old,
            input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = dat[8*i +: 8];
            end
        end
        return res;
    endfunction : byte_merge

    function automatic int burst_peak(input logic [2:0] idx);
        case (idx)
            3'h0: return BURST_PEAK1_UV;
            3'h1: return BURST_PEAK2_UV;
            3'h2: return BURST_PEAK3_UV;
            default: return BURST_PEAK4_UV;
        endcase
    endfunction : burst_peak

    logic [31:0] ctrl_r, burst_a_r, burst_b_r, zvs_line_r, zvs_k_r;
    logic [31:0] timing_r, dat_r;
    logic ack_r, req, run;
    logic [9:0] bulk_v_r;
    logic zvs_en_r, jit_on_r, jit_up_r, exit_pend_r, freq_red_r;
    logic signed [20:0] jit_acc_r;
    fbjz_burst_type bst_r;
    fbjz_mode_type mode_r;
    fbjz_gate_type gst_r;
    logic [11:0] wk_cnt_r;
    logic [2:0] bcnt_r, zc_cnt_r, valley_r;
    logic [15:0] per_cnt_r, gcnt_r, dly_cnt_r, aux_cyc_r, period_t;
    logic zc_seen_r, main_r, zvs_r, main_start, aux_start, valley_up;
    logic main_end;
    logic [19:0] peak_r;
    logic [11:0] fb, entry_lv, exit_lv, wake_lv, pause_lv;

    assign fb = feedback_pin_mv;
    assign entry_lv = burst_a_r[11:0];
    assign exit_lv = burst_a_r[27:16];
    assign wake_lv = burst_b_r[27:16];
    assign pause_lv = burst_b_r[11:0];
    assign run = ctrl_r[0];
    assign req = wb_cyc_i & wb_stb_i & ~ack_r;

    // bus slave: ack one cycle after the request, dropped the next cycle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= req;
            case (wb_adr_i)
                REG_CTRL: dat_r <= ctrl_r;
                REG_BURST_A: dat_r <= burst_a_r;
                REG_BURST_B: dat_r <= burst_b_r;
                REG_ZVS_LINE: dat_r <= zvs_line_r;
                REG_ZVS_K: dat_r <= zvs_k_r;
                REG_TIMING: dat_r <= timing_r;
                REG_STATUS: dat_r <= {21'h000000, freq_red_r,
                    valley_r, zvs_en_r, jit_on_r, 1'b0, bst_r, mode_r};
                default: dat_r <= 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    // writable registers; writes to unmapped or status are dropped;
    // a write lands on the edge at which the master sees ack high
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= CTRL_RST;
            burst_a_r <= BURST_A_RST;
            burst_b_r <= BURST_B_RST;
            zvs_line_r <= ZVS_LINE_RST;
            zvs_k_r <= ZVS_K_RST;
            timing_r <= TIMING_RST;
        end else if (wb_cyc_i && wb_stb_i && wb_we_i && ack_r) begin
            case (wb_adr_i)
                REG_CTRL: ctrl_r <= byte_merge(ctrl_r, wb_dat_i, wb_sel_i)
                    & 32'h0000_0001;
                REG_BURST_A: burst_a_r <= byte_merge(burst_a_r, wb_dat_i,
                    wb_sel_i) & 32'h0FFF_0FFF;
                REG_BURST_B: burst_b_r <= byte_merge(burst_b_r, wb_dat_i,
                    wb_sel_i) & 32'h0FFF_0FFF;
                REG_ZVS_LINE: zvs_line_r <= byte_merge(zvs_line_r,
                    wb_dat_i, wb_sel_i) & 32'h0000_03FF;
                REG_ZVS_K: zvs_k_r <= byte_merge(zvs_k_r, wb_dat_i,
                    wb_sel_i);
                REG_TIMING: timing_r <= byte_merge(timing_r, wb_dat_i,
                    wb_sel_i);
                default: ;
            endcase
        end
    end

    // bulk voltage in volts: microamps times kilohms gives millivolts
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bulk_v_r <= 10'h000;
        end else begin
            bulk_v_r <= 10'((32'(line_sense_ua) * LINE_RES_KOHM)
                / 1000);
        end
    end

    // zvs enable with hysteresis; compare on the high side to avoid wrap
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            zvs_en_r <= 1'b0;
        end else if (32'(bulk_v_r) >= 32'(zvs_line_r[9:0])) begin
            zvs_en_r <= 1'b1;
        end else if (32'(bulk_v_r) + ZVS_HYST_V < 32'(zvs_line_r[9:0])) begin
            zvs_en_r <= 1'b0;
        end
    end

    // aux width: units of 15.8 ns rounded up to whole clocks
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            aux_cyc_r <= 16'h0001;
        end else begin
            aux_cyc_r <= 16'((((32'(bulk_v_r) * 32'(zvs_k_r[15:0]))
                / K_SCALE + ZVS_UNIT_MIN
                + ((32'(zcd_mv) < ZCD_REF_MV)
                ? ((ZCD_REF_MV - 32'(zcd_mv)) * 32'(zvs_k_r[31:16]))
                / (K_SCALE * 1000) : 0)) * ZVS_UNIT_PS
                + CLK_PERIOD_NS * 1000 - 1)
                / (CLK_PERIOD_NS * 1000));
        end
    end

    // jitter enable, holding its state inside the hysteresis band
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            jit_on_r <= 1'b0;
        end else if (32'(fb) < JIT_DIS_FB_MV
                     || 32'(bulk_v_r) < JIT_DIS_BULK_V) begin
            jit_on_r <= 1'b0;
        end else if (32'(fb) >= JIT_EN_FB_MV
                     && 32'(bulk_v_r) >= JIT_EN_BULK_V) begin
            jit_on_r <= 1'b1;
        end
    end

    // triangle sweep in sixteenths of a microvolt; free running, so the
    // offset resumes wherever the sweep stands when jitter is switched back on
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            jit_acc_r <= 21'sh00000;
            jit_up_r <= 1'b1;
        end else if (jit_up_r) begin
            jit_acc_r <= jit_acc_r + 21'(JIT_STEP);
            if (32'(jit_acc_r) + JIT_STEP >= JIT_AMP) begin
                jit_up_r <= 1'b0;
            end
        end else begin
            jit_acc_r <= jit_acc_r - 21'(JIT_STEP);
            if (int'(jit_acc_r) - JIT_STEP <= -JIT_AMP) begin
                jit_up_r <= 1'b1;
            end
        end
    end

    // burst controller: entry, two-point regulation, wake delay, exit
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bst_r <= BS_RUN;
            wk_cnt_r <= 12'h000;
            exit_pend_r <= 1'b0;
        end else if (!run) begin
            bst_r <= BS_RUN;
            exit_pend_r <= 1'b0;
        end else begin
            if (main_end) begin
                exit_pend_r <= 1'b0; // exit peak held for the whole pulse
            end
            case (bst_r)
                BS_RUN: begin
                    if (fb < entry_lv) begin
                        bst_r <= BS_OFF;
                    end
                end
                default: begin
                    if (fb > exit_lv) begin
                        bst_r <= BS_RUN;
                        exit_pend_r <= 1'b1;
                    end else if (bst_r == BS_OFF && fb > wake_lv) begin
                        bst_r <= BS_WAKE;
                        wk_cnt_r <= 12'h000;
                    end else if (bst_r == BS_WAKE) begin
                        if (32'(wk_cnt_r) == WAKE_CYC - 1) begin
                            bst_r <= BS_ON;
                        end
                        wk_cnt_r <= wk_cnt_r + 12'h001;
                    end else if (bst_r == BS_ON && fb <= pause_lv) begin
                        bst_r <= BS_OFF;
                    end
                end
            endcase
        end
    end

    // pulse index within a burst train, saturating at the fourth
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bcnt_r <= 3'h0;
        end else if (bst_r != BS_ON) begin
            bcnt_r <= 3'h0;
        end else if (main_start && bcnt_r != 3'h4) begin
            bcnt_r <= bcnt_r + 3'h1;
        end
    end

    // mode selector from feedback level
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mode_r <= MODE_FIXED;
        end else if (bst_r != BS_RUN) begin
            mode_r <= MODE_BURST;
        end else if (32'(fb) >= FLAW_D_MV && !freq_red_r) begin
            mode_r <= MODE_RESONANT;
        end else if (32'(fb) >= FLAW_E_MV) begin
            mode_r <= MODE_FREQRED;
        end else begin
            mode_r <= MODE_FIXED;
        end
    end

    // valley stepping: a valley reached before the minimum period means
    // the frequency hit the band's upper edge
    assign valley_up = zcd_pulse && gst_r == GS_WAIT && !zvs_en_r
        && mode_r == MODE_RESONANT && zc_cnt_r + 3'h1 == valley_r
        && per_cnt_r < period_t;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            valley_r <= 3'h1;
            freq_red_r <= 1'b0;
        end else if (32'(fb) < FLAW_D_MV) begin
            freq_red_r <= 1'b0;
            valley_r <= 3'h1;
        end else if (valley_up) begin
            if (32'(valley_r) < MAX_VALLEY) begin
                valley_r <= valley_r + 3'h1;
            end else begin
                freq_red_r <= 1'b1;
            end
        end else if (main_start && mode_r == MODE_RESONANT
                     && per_cnt_r >= {period_t[14:0], 1'b0}
                     && valley_r != 3'h1) begin
            valley_r <= valley_r - 3'h1; // load rose, step back
        end
    end

    always_comb begin
        if (mode_r == MODE_BURST) begin
            period_t = 16'(BURST_PERIOD_CYC);
        end else if (mode_r == MODE_FIXED) begin
            period_t = 16'(DCM1_PERIOD);
        end else begin
            period_t = timing_r[15:0];
        end
    end

    // main gate start without an aux pulse, or aux pulse start in zvs mode
    always_comb begin
        main_start = 1'b0;
        aux_start = 1'b0;
        // the mode register trails the burst state by a cycle; no start
        // while the two disagree
        if (run && gst_r == GS_WAIT
            && (bst_r == BS_RUN || mode_r == MODE_BURST)) begin
            case (mode_r)
                MODE_BURST: main_start = bst_r == BS_ON
                    && (bcnt_r == 3'h0 || per_cnt_r >= period_t);
                MODE_RESONANT: begin
                    if (zvs_en_r) begin
                        aux_start = zc_seen_r
                            && dly_cnt_r >= timing_r[31:16]
                            && 32'(per_cnt_r) + 32'(aux_cyc_r) + DEAD_CYC
                            >= 32'(period_t);
                    end else begin
                        main_start = per_cnt_r >= period_t
                            && zc_cnt_r >= valley_r;
                    end
                end
                default: main_start = per_cnt_r >= period_t;
            endcase
        end
    end

    // main pulse end; a burst-off phase halts switching at once
    assign main_end = gst_r == GS_MAIN && (cs_trip
        || 32'(gcnt_r) >= MAX_ON_CYC - 1 || bst_r == BS_OFF || !run);

    // gate sequencer; outputs are registered beside the state
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            gst_r <= GS_WAIT;
            gcnt_r <= 16'h0000;
            main_r <= 1'b0;
            zvs_r <= 1'b0;
        end else begin
            gcnt_r <= gcnt_r + 16'h0001;
            case (gst_r)
                GS_WAIT: begin
                    gcnt_r <= 16'h0000;
                    if (aux_start) begin
                        gst_r <= GS_AUX;
                        zvs_r <= 1'b1;
                    end else if (main_start) begin
                        gst_r <= GS_MAIN;
                        main_r <= 1'b1;
                    end
                end
                GS_AUX: begin
                    if (gcnt_r + 16'h0001 >= aux_cyc_r) begin
                        gst_r <= GS_DEAD;
                        zvs_r <= 1'b0;
                        gcnt_r <= 16'h0000;
                    end
                end
                GS_DEAD: begin
                    if (bst_r == BS_OFF || !run) begin
                        gst_r <= GS_WAIT; // burst-off wins over turn-on
                    end else if (32'(gcnt_r) == DEAD_CYC - 1) begin
                        gst_r <= GS_MAIN;
                        main_r <= 1'b1;
                        gcnt_r <= 16'h0000;
                    end
                end
                default: begin
                    if (main_end) begin
                        gst_r <= GS_WAIT;
                        main_r <= 1'b0;
                    end
                end
            endcase
        end
    end

    // period, zero-crossing count and delay since the last crossing
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            per_cnt_r <= 16'h0000;
            zc_cnt_r <= 3'h0;
            zc_seen_r <= 1'b0;
            dly_cnt_r <= 16'h0000;
        end else begin
            if (per_cnt_r != 16'hFFFF) begin
                per_cnt_r <= per_cnt_r + 16'h0001;
            end
            if (dly_cnt_r != 16'hFFFF) begin
                dly_cnt_r <= dly_cnt_r + 16'h0001;
            end
            if ((gst_r == GS_DEAD && 32'(gcnt_r) == DEAD_CYC - 1)
                || main_start) begin
                per_cnt_r <= 16'h0000; // period timed from turn-on
                zc_cnt_r <= 3'h0;
                zc_seen_r <= 1'b0;
            end else if (zcd_pulse && gst_r == GS_WAIT) begin
                zc_seen_r <= 1'b1;
                dly_cnt_r <= 16'h0000;
                if (zc_cnt_r != 3'h7) begin
                    zc_cnt_r <= zc_cnt_r + 3'h1;
                end
            end
        end
    end

    // peak limit: exit pulse, burst ramp, law value, plus jitter offset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            peak_r <= 20'h00000;
        end else if (exit_pend_r) begin
            peak_r <= 20'(EXIT_PEAK_UV);
        end else if (bst_r != BS_RUN) begin
            // during a pulse the index has already moved to the next one
            peak_r <= 20'(burst_peak(gst_r == GS_MAIN ? bcnt_r - 3'h1
                : bcnt_r));
        end else if (mode_r == MODE_FREQRED) begin
            peak_r <= 20'(FLAW_D_PEAK_UV + (jit_on_r
                ? int'(jit_acc_r) / JIT_SUB : 0));
        end else begin
            peak_r <= 20'((32'(fb) * PEAK_GAIN_UV > PEAK_MAX_UV
                ? PEAK_MAX_UV : int'(32'(fb) * PEAK_GAIN_UV))
                + (jit_on_r ? int'(jit_acc_r) / JIT_SUB : 0));
        end
    end

    assign wb_dat_o = dat_r;
    assign wb_ack_o = ack_r;
    assign main_gate_output = main_r;
    assign zvs_gate_output = zvs_r;
    assign peak_limit_uv = peak_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_jitter_on_cause: assert property ($rose(jit_on_r) |->
        $past(32'(fb) >= JIT_EN_FB_MV && 32'(bulk_v_r) >= JIT_EN_BULK_V))
        else $error("jitter enabled without its condition");
    a_jitter_off_now: assert property ((32'(fb) < JIT_DIS_FB_MV) |=>
        !jit_on_r) else $error("jitter not disabled");
    a_jitter_hold_band: assert property ((32'(fb) >= JIT_DIS_FB_MV
        && 32'(fb) < JIT_EN_FB_MV && 32'(bulk_v_r) >= JIT_DIS_BULK_V)
        |=> $stable(jit_on_r)) else $error("jitter changed in band");
    a_burst_entry_off: assert property ((run && bst_r == BS_RUN
        && fb < entry_lv) |=> bst_r == BS_OFF ##1 !main_gate_output)
        else $error("burst entry without off phase");
    a_wake_no_gate: assert property ($rose(bst_r == BS_WAKE) |->
        (!main_gate_output)[*8] ##0 (bst_r == BS_WAKE))
        else $error("gate during wake delay");
    a_wake_length: assert property ($rose(bst_r == BS_ON) |->
        $past(32'(wk_cnt_r) == WAKE_CYC - 1))
        else $error("wake delay length wrong");
    a_burst_exit_now: assert property ((run && bst_r != BS_RUN
        && fb > exit_lv) |=> bst_r == BS_RUN && exit_pend_r)
        else $error("burst exit delayed");
    a_dead_time: assert property ($fell(zvs_gate_output) |->
        (!main_gate_output)[*8] ##17 main_gate_output)
        else $error("dead time not 24 cycles");
    a_gates_exclusive: assert property (!(main_gate_output
        && zvs_gate_output)) else $error("both gates on");
    a_valley_range: assert property (valley_r >= 3'h1
        && 32'(valley_r) <= MAX_VALLEY)
        else $error("valley index out of range");

    c_burst_cycle: cover property (bst_r == BS_WAKE
        && 32'(wk_cnt_r) == WAKE_CYC - 1 ##1 bst_r == BS_ON);
    c_zvs_sequence: cover property ($rose(zvs_gate_output)
        ##[1:300] $rose(main_gate_output));
    c_valley_step: cover property (valley_up);
    c_jitter_on: cover property ($rose(jit_on_r));
endmodule : fbjz_core

// [rtl/fbjz_pkg.sv]
package fbjz_pkg;
    // clock and fixed timings
    localparam int CLK_PERIOD_NS = 10;
    localparam int DEAD_TIME_NS = 236;
    localparam int DEAD_CYC = (DEAD_TIME_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
    localparam int WAKE_DELAY_NS = 26600;
    localparam int WAKE_CYC = (WAKE_DELAY_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
    localparam int JIT_PERIOD_NS = 1000000;
    localparam int JIT_PERIOD_CYC = JIT_PERIOD_NS / CLK_PERIOD_NS;
    localparam int DCM1_PERIOD_NS = 43478;
    localparam int DCM1_PERIOD_CYC = DCM1_PERIOD_NS / CLK_PERIOD_NS;
    localparam int BURST_PERIOD_CYC = 1000;
    localparam int MAX_ON_CYC = 1000;
    // jitter thresholds and amplitude
    localparam int JIT_EN_FB_MV = 1000;
    localparam int JIT_DIS_FB_MV = 900;
    localparam int JIT_EN_BULK_V = 175;
    localparam int JIT_DIS_BULK_V = 150;
    localparam int JIT_AMP_UV = 15625;
    localparam int JIT_SUB = 16;
    // frequency law corners and peak limits
    localparam int FLAW_E_MV = 860;
    localparam int FLAW_D_MV = 1230;
    localparam int FLAW_D_PEAK_UV = 260000;
    localparam int PEAK_GAIN_UV = 175;
    localparam int PEAK_MAX_UV = 402000;
    localparam int EXIT_PEAK_UV = 200000;
    localparam int BURST_PEAK1_UV = 100000;
    localparam int BURST_PEAK2_UV = 130000;
    localparam int BURST_PEAK3_UV = 160000;
    localparam int BURST_PEAK4_UV = 190000;
    // zvs pulse width law and line sensing
    localparam int ZVS_HYST_V = 20;
    localparam int K_SCALE = 65535;
    localparam int ZCD_REF_MV = 2340;
    localparam int ZVS_UNIT_PS = 15800;
    localparam int ZVS_UNIT_MIN = 2;
    localparam int LINE_RES_KOHM = 102;
    localparam int MAX_VALLEY = 6;
    // register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_BURST_A = 8'h04;
    localparam logic [7:0] REG_BURST_B = 8'h08;
    localparam logic [7:0] REG_ZVS_LINE = 8'h0C;
    localparam logic [7:0] REG_ZVS_K = 8'h10;
    localparam logic [7:0] REG_TIMING = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam logic [31:0] BURST_A_RST = 32'h0258_00B4;
    localparam logic [31:0] BURST_B_RST = 32'h012C_00DC;
    localparam logic [31:0] ZVS_LINE_RST = 32'h0000_00FA;
    localparam logic [31:0] ZVS_K_RST = 32'h4000_8000;
    localparam logic [31:0] TIMING_RST = 32'h0014_0320;

    typedef enum logic [1:0] {
        MODE_BURST, MODE_FIXED, MODE_FREQRED, MODE_RESONANT
    } fbjz_mode_type;
    typedef enum logic [1:0] {BS_RUN, BS_OFF, BS_WAKE, BS_ON} fbjz_burst_type;
    typedef enum logic [1:0] {GS_WAIT, GS_AUX, GS_DEAD, GS_MAIN} fbjz_gate_type;
endpackage : fbjz_pkg

// [verification/fbjz_stage.sv]
`timescale 1ns/1ps
module fbjz_stage (
    input wire logic sys_clk,
    input wire logic main_gate_output,
    output logic cs_trip = 1'b0,
    output logic zcd_pulse = 1'b0
);
    int on_cnt = 0;
    int off_cnt = 0;
    // current ramp trips after 40 cycles; ringing crosses zero every 60
    always @(posedge sys_clk) begin
        on_cnt <= main_gate_output ? on_cnt + 1 : 0;
        off_cnt <= main_gate_output ? 0 : off_cnt + 1;
        cs_trip <= main_gate_output && on_cnt == 40;
        zcd_pulse <= off_cnt % 60 == 30;
    end
endmodule : fbjz_stage

// [verification/test_flyback_burst_jitter_zvs_control.sv]
`timescale 1ns/1ps
module test_flyback_burst_jitter_zvs_control import fbjz_pkg::*; ();
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [11:0] feedback_pin_mv = 12'h44C, line_sense_ua = 12'h7D0;
    logic [11:0] zcd_mv = 12'h7D0;
    logic wb_ack_o, zcd_pulse, cs_trip, main_gate_output, zvs_gate_output;
    logic [19:0] peak_limit_uv;
    int err_total = 0, n_compared = 0;
    always #5 sys_clk = ~sys_clk;
    // short jitter period keeps the run brief
    fbjz_core #(.JIT_PERIOD(1000), .DCM1_PERIOD(100)) dut (.sys_clk, .rstn,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .feedback_pin_mv, .line_sense_ua, .zcd_mv,
        .zcd_pulse, .cs_trip, .main_gate_output, .zvs_gate_output,
        .peak_limit_uv);
    fbjz_stage stage (.sys_clk, .main_gate_output, .cs_trip, .zcd_pulse);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // classic cycle: hold until ack is sampled, then release
    task wb(input logic [7:0] a, input logic we, input logic [31:0] d);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        // a missing ack is left to the watchdog
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    task lvl(input logic [11:0] f, input logic [11:0] u);
        @(posedge sys_clk);
        feedback_pin_mv <= f;
        line_sense_ua <= u;
        repeat (6) @(posedge sys_clk);
        wb(REG_STATUS, 1'b0, 32'h0);
    endtask : lvl
    task t_regs;
        wb(REG_CTRL, 1'b0, 32'h0);
        chk(rd, CTRL_RST);
        wb(REG_CTRL, 1'b1, 32'h0);
        wb(REG_CTRL, 1'b0, 32'h0);
        chk(rd, 32'h0);
        wb(REG_CTRL, 1'b1, CTRL_RST);
        wb(8'hFC, 1'b0, 32'h0);
        chk(rd, 32'h0);
        $display("t_regs done");
    endtask : t_regs
    // bulk volts = ua * 102 / 1000: 2000 -> 204, 1400 -> 142, 1600 -> 163
    task t_jit;
        lvl(12'h44C, 12'h7D0);
        chk(rd[5], 1'b1);
        chk(rd[1:0], 2'h2);
        lvl(12'h3B6, 12'h7D0);
        chk(rd[5], 1'b1);
        lvl(12'h352, 12'h7D0);
        chk(rd[5], 1'b0);
        chk(rd[1:0], 2'h1);
        lvl(12'h514, 12'h578);
        chk(rd[5], 1'b0);
        chk(rd[1:0], 2'h3);
        lvl(12'h514, 12'h640);
        chk(rd[5], 1'b0);
        $display("t_jit done");
    endtask : t_jit
    task t_burst;
        int first;
        first = 0;
        lvl(12'h064, 12'h7D0);
        chk(rd[3:2], 2'h1);
        chk(main_gate_output, 1'b0);
        @(posedge sys_clk);
        feedback_pin_mv <= 12'h190;
        for (int i = 0; i < 2700 && first == 0; i++) begin
            @(negedge sys_clk);
            if (main_gate_output === 1'b1) first = i;
        end
        chk(first >= 2655 && first <= 2670, 1'b1);
        chk(peak_limit_uv, BURST_PEAK1_UV);
        lvl(12'h0C8, 12'h7D0);
        chk(rd[3:2], 2'h1);
        lvl(12'h2BC, 12'h7D0);
        chk(rd[3:2], 2'h0);
        chk(peak_limit_uv, EXIT_PEAK_UV);
        while (main_gate_output !== 1'b1) @(negedge sys_clk);
        repeat (20) @(negedge sys_clk);
        chk(peak_limit_uv, EXIT_PEAK_UV);
        repeat (40) @(negedge sys_clk);
        chk(peak_limit_uv, 12'h2BC * PEAK_GAIN_UV);
        $display("t_burst done");
    endtask : t_burst
    // bulk 261 V enables the aux gate; dead time counted from its fall
    task t_zvs;
        int n;
        n = 0;
        lvl(12'h514, 12'hA00);
        chk(rd[6], 1'b1);
        while (zvs_gate_output !== 1'b1) @(negedge sys_clk);
        while (zvs_gate_output === 1'b1) @(negedge sys_clk);
        while (main_gate_output !== 1'b1) begin
            chk(zvs_gate_output, 1'b0);
            @(negedge sys_clk);
            n++;
        end
        chk(n, DEAD_CYC);
        $display("t_zvs done");
    endtask : t_zvs
    task end_sim;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        end_sim;
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        t_regs;
        t_jit;
        t_burst;
        t_zvs;
        end_sim;
    end
endmodule : test_flyback_burst_jitter_zvs_control
